// >>> xbh_host.sv
`timescale 1ns/1ps

module xbh_host #(
    parameter logic [31:0] RESET_WAIT_CYC = xbh_pkg::RESET_WAIT_CYC
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Command port: one bus cycle per accepted legal command; an accepted illegal command gets only an error response.
    input wire logic i_cmd_valid,
    input wire logic [2:0] i_cmd_mode,
    input wire logic [7:0] i_cmd_data,
    output logic o_cmd_ready,
    // Response port.
    output logic o_rsp_valid,
    output logic o_rsp_err,
    output logic [7:0] o_rsp_data,
    // Bus pins.
    output logic [2:0] o_mode_lines,
    output logic o_cycle_strobe_n,
    output logic [7:0] o_bus_data,
    output logic o_bus_data_oe,
    input wire logic [7:0] i_bus_data,
    input wire logic i_attention_request_n,
    // Status.
    output logic o_attention,
    output logic o_reset_done
);

    xbh_pkg::xbh_state_t state_q;
    logic [31:0] cnt_q;
    logic [2:0] mode_q;
    logic [7:0] data_q;
    logic oe_q;
    logic strobe_n_q;
    logic ready_q;
    logic rsp_valid_q;
    logic rsp_err_q;
    logic [7:0] rsp_data_q;
    logic reset_done_q;
    logic [1:0] addr_done_q;
    logic [1:0] cat_cnt_q;
    logic attention_q;
    logic [7:0] data_sync;
    logic att_sync_n;

    // Pin inputs pass two flops before any use.
    xbh_sync #(.WIDTH(8), .RST_VAL(xbh_pkg::DATA_RST)) u_data_sync (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_d(i_bus_data),
        .o_q(data_sync)
    );
    xbh_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_att_sync (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_d(i_attention_request_n),
        .o_q(att_sync_n)
    );

    // Command decode and acceptance checks.
    wire accept = i_cmd_valid && ready_q && (state_q == xbh_pkg::ST_IDLE);
    wire is_reset = (i_cmd_mode == xbh_pkg::BUS_RESET_CYCLE);
    wire is_addr = i_cmd_mode[xbh_pkg::MODE_ADDR_BIT] && (i_cmd_mode != xbh_pkg::DATA_WRITE_CYCLE);
    wire is_addr0 = (i_cmd_mode == xbh_pkg::ADDRESS_CYCLE_0);
    wire [1:0] addr_idx = i_cmd_mode[1:0];
    wire drives = i_cmd_mode[xbh_pkg::MODE_ADDR_BIT];
    wire [3:0] cat = i_cmd_data[xbh_pkg::CAT_MSB:0];
    // Address cycles per category.
    wire [1:0] cat_cnt = (!cat[3]) ? xbh_pkg::CNT_THREE :
                         (cat[3:1] == 3'h4) ? xbh_pkg::CNT_THREE :
                         (cat[3:1] == 3'h5) ? xbh_pkg::CNT_ONE :
                         (cat == 4'hc) ? xbh_pkg::CNT_TWO :
                         (cat == 4'hd) ? xbh_pkg::CNT_THREE : xbh_pkg::CNT_ONE;
    // Later address bytes only within the category and in order, or any byte already placed alone again.
    wire addr_ok = is_addr0 || ((addr_idx < cat_cnt_q) && (addr_idx <= addr_done_q));
    wire data_ok = (addr_done_q != xbh_pkg::ADDR_DONE_RST);
    wire legal = is_reset || (reset_done_q && (is_addr ? addr_ok : data_ok));
    wire start = accept && legal;
    wire cnt_zero = (cnt_q == 32'h0);
    wire [1:0] addr_next = (addr_idx + 2'h1 > addr_done_q) ? 2'(addr_idx + 2'h1) : addr_done_q;

    // Cycle engine state.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= xbh_pkg::ST_IDLE;
            cnt_q <= 32'h0;
        end else begin
            unique case (state_q)
                xbh_pkg::ST_IDLE: begin
                    if (start) begin
                        state_q <= xbh_pkg::ST_SETUP;
                        cnt_q <= xbh_pkg::SETUP_CYC - 32'h1;
                    end
                end
                xbh_pkg::ST_SETUP: begin
                    cnt_q <= cnt_q - 32'h1;
                    if (cnt_zero) begin
                        state_q <= xbh_pkg::ST_STROBE;
                        cnt_q <= xbh_pkg::STROBE_CYC - 32'h1;
                    end
                end
                xbh_pkg::ST_STROBE: begin
                    cnt_q <= cnt_q - 32'h1;
                    if (cnt_zero) begin
                        state_q <= xbh_pkg::ST_HOLD;
                        cnt_q <= xbh_pkg::HOLD_CYC - 32'h1;
                    end
                end
                xbh_pkg::ST_HOLD: begin
                    cnt_q <= cnt_q - 32'h1;
                    if (cnt_zero && mode_q == xbh_pkg::BUS_RESET_CYCLE) begin
                        state_q <= xbh_pkg::ST_WAIT;
                        cnt_q <= RESET_WAIT_CYC - 32'h1;
                    end else if (cnt_zero) begin
                        state_q <= xbh_pkg::ST_IDLE;
                    end
                end
                xbh_pkg::ST_WAIT: begin
                    cnt_q <= cnt_q - 32'h1;
                    if (cnt_zero) begin
                        state_q <= xbh_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Mode and data stay stable from setup through hold around the strobe.
    wire done = cnt_zero && ((state_q == xbh_pkg::ST_HOLD && mode_q != xbh_pkg::BUS_RESET_CYCLE) ||
                             state_q == xbh_pkg::ST_WAIT);
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_q <= xbh_pkg::MODE_RST;
            data_q <= xbh_pkg::DATA_RST;
            oe_q <= 1'b0;
            strobe_n_q <= 1'b1;
        end else begin
            if (start) begin
                mode_q <= i_cmd_mode;
                data_q <= drives ? i_cmd_data : xbh_pkg::DATA_RST;
                oe_q <= drives;
            end else if (state_q == xbh_pkg::ST_HOLD && cnt_zero) begin
                oe_q <= 1'b0;
            end
            strobe_n_q <= !((state_q == xbh_pkg::ST_SETUP && cnt_zero) ||
                            (state_q == xbh_pkg::ST_STROBE && !cnt_zero));
        end
    end

    // Responses, read sampling and sequence bookkeeping.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_err_q <= 1'b0;
            rsp_data_q <= xbh_pkg::DATA_RST;
            reset_done_q <= 1'b0;
            addr_done_q <= xbh_pkg::ADDR_DONE_RST;
            cat_cnt_q <= xbh_pkg::CNT_ONE;
            attention_q <= 1'b0;
        end else begin
            ready_q <= (state_q == xbh_pkg::ST_IDLE) ? !start : done;
            rsp_valid_q <= done || (accept && !legal);
            rsp_err_q <= accept && !legal;
            attention_q <= !att_sync_n;
            if (state_q == xbh_pkg::ST_STROBE && cnt_zero) begin
                rsp_data_q <= oe_q ? xbh_pkg::DATA_RST : data_sync;
            end
            if (start && is_reset) begin
                reset_done_q <= 1'b1;
                addr_done_q <= xbh_pkg::ADDR_DONE_RST;
            end else if (start && is_addr0) begin
                cat_cnt_q <= cat_cnt;
                addr_done_q <= 2'h1;
            end else if (start && is_addr) begin
                addr_done_q <= addr_next;
            end
        end
    end

    assign o_cmd_ready = ready_q;
    assign o_rsp_valid = rsp_valid_q;
    assign o_rsp_err = rsp_err_q;
    assign o_rsp_data = rsp_data_q;
    assign o_mode_lines = mode_q;
    assign o_cycle_strobe_n = strobe_n_q;
    assign o_bus_data = data_q;
    assign o_bus_data_oe = oe_q;
    assign o_attention = attention_q;
    assign o_reset_done = reset_done_q;

    // Checks on the pin sequencing and command policy.
    localparam int HOLD_WIN = 12;

    a_mode_stable: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !o_cycle_strobe_n && !$past(o_cycle_strobe_n) |-> $stable(o_mode_lines))
        else $error("mode lines changed during strobe");
    a_read_release: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !o_cycle_strobe_n && !o_mode_lines[2] |-> !o_bus_data_oe)
        else $error("host drives data in a read or reset cycle");
    a_addr_drive: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !o_cycle_strobe_n && o_mode_lines[2] |-> o_bus_data_oe && $stable(o_bus_data))
        else $error("address or write data not driven steadily");
    a_strobe_width: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $fell(o_cycle_strobe_n) |-> !o_cycle_strobe_n [*8])
        else $error("strobe pulse too short");
    a_refuse_early: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        accept && !reset_done_q && !is_reset |=> o_rsp_err && o_rsp_valid && o_cmd_ready)
        else $error("command before bus reset not refused");
    a_addr_count: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $fell(o_cycle_strobe_n) && o_mode_lines[2] && o_mode_lines != 3'h7 && o_mode_lines != 3'h4
        |-> o_mode_lines[1:0] < cat_cnt_q)
        else $error("address cycle beyond category length");
    a_data_after_addr: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $fell(o_cycle_strobe_n) && (o_mode_lines == 3'h7 || o_mode_lines < 3'h3) |-> addr_done_q != 2'h0)
        else $error("data cycle with no address placed");
    a_rsp_after: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(o_cycle_strobe_n) && o_mode_lines != 3'h3 |-> ##[1:HOLD_WIN] o_rsp_valid && !o_rsp_err)
        else $error("no response after read or write cycle");
    a_attention: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $fell(att_sync_n) |=> o_attention)
        else $error("attention request not reported");

    c_read: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $fell(o_cycle_strobe_n) && o_mode_lines == 3'h0);
    c_write: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $fell(o_cycle_strobe_n) && o_mode_lines == 3'h7);
    c_reset: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $fell(o_cycle_strobe_n) && o_mode_lines == 3'h3);
    c_abbrev: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        start && i_cmd_mode == 3'h6 && addr_done_q == 2'h3);

endmodule // xbh_host

// >>> xbh_pkg.sv
package xbh_pkg;

    // Cycle codes carried on the three mode lines.
    localparam logic [2:0] READ_CYCLE_0 = 3'h0;
    localparam logic [2:0] READ_CYCLE_1 = 3'h1;
    localparam logic [2:0] READ_CYCLE_2 = 3'h2;
    localparam logic [2:0] BUS_RESET_CYCLE = 3'h3;
    localparam logic [2:0] ADDRESS_CYCLE_0 = 3'h4;
    localparam logic [2:0] ADDRESS_CYCLE_1 = 3'h5;
    localparam logic [2:0] ADDRESS_CYCLE_2 = 3'h6;
    localparam logic [2:0] DATA_WRITE_CYCLE = 3'h7;

    // Field positions inside the first address byte and the mode code.
    localparam int CAT_MSB = 3;
    localparam int MODE_ADDR_BIT = 2;

    // Reset values of the pin-facing registers and of the placed-address count.
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] ADDR_DONE_RST = 2'h0;

    // Number of address cycles that each category uses.
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [1:0] CNT_TWO = 2'h2;
    localparam logic [1:0] CNT_THREE = 2'h3;

    // Bus timing in nanoseconds and the derived clock counts at 100 MHz.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS = 100;
    localparam int STROBE_NS = 500;
    localparam int HOLD_NS = 100;
    localparam int RESET_WAIT_NS = 350000000;
    localparam logic [31:0] SETUP_CYC = 32'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [31:0] STROBE_CYC = 32'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [31:0] HOLD_CYC = 32'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [31:0] RESET_WAIT_CYC = 32'((RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Cycle engine states.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_STROBE = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_WAIT = 5'b10000
    } xbh_state_t;

endpackage

// >>> xbh_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser for pins that arrive from outside the clock domain.
module xbh_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Asynchronous input and its synchronised copy.
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_q;

    // The first stage is read only by the second stage.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_q <= RST_VAL;
            o_q <= RST_VAL;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end

endmodule // xbh_sync

// >>> xbh_periph.sv
`timescale 1ns/1ps

// Peripheral model: a category 1101 device with three read bytes and an expansion register.
module xbh_periph #(
    parameter logic [7:0] ADDR0 = 8'h5d,
    parameter logic [7:0] ADDR1 = 8'h12,
    parameter logic [7:0] ADDR2 = 8'h34
) (
    // Bus pins seen from the peripheral.
    input wire logic [2:0] i_mode_lines,
    input wire logic i_cycle_strobe_n,
    input wire logic [7:0] i_bus_data,
    input wire logic i_bus_data_oe,
    output logic [7:0] o_bus_level,
    output logic o_attention_request_n,
    // Internal state for the bench to observe.
    output logic o_selected,
    output logic [7:0] o_data_reg,
    output logic [7:0] o_exp_reg
);
    logic [7:0] adr [3];
    logic exp_sel;
    logic [7:0] rd_byte;
    logic drive;

    // Read byte per cycle, selection and line level; undriven lines show the inverse of the read byte.
    assign rd_byte = (i_mode_lines == xbh_pkg::READ_CYCLE_0) ? o_data_reg :
                     (i_mode_lines == xbh_pkg::READ_CYCLE_1) ? ~o_data_reg : o_data_reg ^ 8'h5a;
    assign o_selected = (adr[0] == ADDR0) && (adr[1] == ADDR1) && (adr[2] == ADDR2);
    assign drive = o_selected && !i_cycle_strobe_n && (i_mode_lines <= xbh_pkg::READ_CYCLE_2);
    assign o_bus_level = i_bus_data_oe ? i_bus_data : (drive ? rd_byte : ~rd_byte);
    assign o_attention_request_n = ~o_data_reg[7];

    // Power-up state.
    initial begin
        adr = '{8'h00, 8'h00, 8'h00};
        exp_sel = 1'b0;
        o_data_reg = 8'h00;
        o_exp_reg = 8'h00;
    end

    // Each cycle is acted on at the end of its strobe, with no timing of its own.
    always @(posedge i_cycle_strobe_n) begin
        case (i_mode_lines)
            xbh_pkg::BUS_RESET_CYCLE: begin
                adr = '{8'h00, 8'h00, 8'h00};
                exp_sel = 1'b0;
                o_data_reg = 8'h00;
                o_exp_reg = 8'h00;
            end
            xbh_pkg::ADDRESS_CYCLE_0: begin
                adr = '{i_bus_data, 8'h00, 8'h00};
                exp_sel = (i_bus_data == 8'h0b);
            end
            xbh_pkg::ADDRESS_CYCLE_1: adr[1] = i_bus_data;
            xbh_pkg::ADDRESS_CYCLE_2: adr[2] = i_bus_data;
            xbh_pkg::DATA_WRITE_CYCLE: begin
                if (exp_sel) o_exp_reg = i_bus_data;
                else if (o_selected) o_data_reg = i_bus_data;
            end
            default: ;
        endcase
    end
endmodule // xbh_periph

// >>> xbh_host_tb.sv
`timescale 1ns/1ps

module xbh_host_tb;
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_cmd_valid = 1'b0;
    logic [2:0] i_cmd_mode = 3'h0;
    logic [7:0] i_cmd_data = 8'h00;
    logic o_cmd_ready, o_rsp_valid, o_rsp_err, o_cycle_strobe_n, o_bus_data_oe, o_attention, o_reset_done;
    logic [2:0] o_mode_lines;
    logic [7:0] o_rsp_data, o_bus_data, line_level, data_reg, exp_reg, d;
    logic attn_n, sel;
    logic [9:0] exp_q [$];
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 32'hefe5fc25;
    logic [3:0] cats [4] = '{4'h3, 4'h6, 4'h9, 4'he};

    xbh_host #(.RESET_WAIT_CYC(32'h8)) u_xbh_host (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
        .i_cmd_valid(i_cmd_valid), .i_cmd_mode(i_cmd_mode), .i_cmd_data(i_cmd_data), .o_cmd_ready(o_cmd_ready),
        .o_rsp_valid(o_rsp_valid), .o_rsp_err(o_rsp_err), .o_rsp_data(o_rsp_data), .o_mode_lines(o_mode_lines),
        .o_cycle_strobe_n(o_cycle_strobe_n), .o_bus_data(o_bus_data), .o_bus_data_oe(o_bus_data_oe),
        .i_bus_data(line_level), .i_attention_request_n(attn_n), .o_attention(o_attention),
        .o_reset_done(o_reset_done));

    xbh_periph u_xbh_periph (.i_mode_lines(o_mode_lines), .i_cycle_strobe_n(o_cycle_strobe_n),
        .i_bus_data(o_bus_data), .i_bus_data_oe(o_bus_data_oe), .o_bus_level(line_level),
        .o_attention_request_n(attn_n), .o_selected(sel), .o_data_reg(data_reg), .o_exp_reg(exp_reg));

    // Clock generation.
    initial forever #5 i_sys_clk = ~i_sys_clk;

    // Compares one value and counts any mismatch.
    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        checked++;
        if (seen !== expected) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic stop_test;
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Note for a finished cycle whose read-back byte is known.
    function automatic logic [9:0] ok(input logic [7:0] v);
        return {2'b10, v};
    endfunction

    // Issues one command, notes its expected answer and waits for the response.
    task automatic cmd(input logic [2:0] mode, input logic [7:0] data, input logic [9:0] note);
        exp_q.push_back(note);
        @(posedge i_sys_clk);
        i_cmd_valid <= 1'b1;
        i_cmd_mode <= mode;
        i_cmd_data <= data;
        @(posedge i_sys_clk);
        while (o_cmd_ready !== 1'b1) @(posedge i_sys_clk);
        i_cmd_valid <= 1'b0;
        while (o_rsp_valid !== 1'b1) @(posedge i_sys_clk);
        if (note[8] == 1'b0) check({5'h0, o_mode_lines}, {5'h0, mode});
    endtask

    // Cycle limit: a hang counts as a mismatch and goes to the verdict.
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    // Response watcher takes the oldest note for every response.
    always @(posedge i_sys_clk) begin
        if (o_bus_data_oe === 1'b1) check({7'h0, o_mode_lines[2]}, 8'h01);
        if (o_rsp_valid === 1'b1) begin
            d = exp_q[0][7:0];
            check({7'h0, o_rsp_err}, {7'h0, exp_q[0][8]});
            check({7'h0, o_cmd_ready}, 8'h01);
            if (exp_q[0][9]) check(o_rsp_data, d);
            void'(exp_q.pop_front());
        end
    end

    // Main sequence.
    initial begin
        logic [7:0] v;
        logic [7:0] last_v;
        repeat (12) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        cmd(xbh_pkg::READ_CYCLE_0, 8'h00, 10'h100);
        cmd(xbh_pkg::BUS_RESET_CYCLE, 8'h00, 10'h000);
        check({7'h0, o_reset_done}, 8'h01);
        cmd(xbh_pkg::ADDRESS_CYCLE_1, 8'h12, 10'h100);
        cmd(xbh_pkg::ADDRESS_CYCLE_0, 8'h5d, ok(8'h00));
        cmd(xbh_pkg::ADDRESS_CYCLE_1, 8'h12, ok(8'h00));
        cmd(xbh_pkg::ADDRESS_CYCLE_2, 8'h34, ok(8'h00));
        check({7'h0, sel}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            if (i == 3) v = v | 8'h80;
            cmd(xbh_pkg::DATA_WRITE_CYCLE, v, ok(8'h00));
            check(data_reg, v);
            cmd(xbh_pkg::READ_CYCLE_0, 8'h00, ok(v));
            cmd(xbh_pkg::READ_CYCLE_1, 8'h00, ok(~v));
            cmd(xbh_pkg::READ_CYCLE_2, 8'h00, ok(v ^ 8'h5a));
            last_v = v;
        end
        repeat (6) @(posedge i_sys_clk);
        check({7'h0, o_attention}, 8'h01);
        cmd(xbh_pkg::ADDRESS_CYCLE_2, 8'h35, ok(8'h00));
        check({7'h0, sel}, 8'h00);
        cmd(xbh_pkg::DATA_WRITE_CYCLE, 8'h77, ok(8'h00));
        check(data_reg, last_v);
        cmd(xbh_pkg::ADDRESS_CYCLE_2, 8'h34, ok(8'h00));
        cmd(xbh_pkg::READ_CYCLE_0, 8'h00, ok(last_v));
        cmd(xbh_pkg::ADDRESS_CYCLE_0, 8'h0b, ok(8'h00));
        cmd(xbh_pkg::ADDRESS_CYCLE_1, 8'h00, 10'h100);
        cmd(xbh_pkg::DATA_WRITE_CYCLE, 8'h03, ok(8'h00));
        check(exp_reg, 8'h03);
        check(data_reg, last_v);
        cmd(xbh_pkg::ADDRESS_CYCLE_0, 8'h0c, ok(8'h00));
        cmd(xbh_pkg::ADDRESS_CYCLE_1, 8'h12, ok(8'h00));
        cmd(xbh_pkg::ADDRESS_CYCLE_2, 8'h34, 10'h100);
        // Categories 0xxx and 100x take three address cycles, 111x only one; upper bits are random.
        for (int k = 0; k < 4; k++) begin
            v = 8'($random(seed));
            cmd(xbh_pkg::ADDRESS_CYCLE_0, {v[7:4], cats[k]}, ok(8'h00));
            cmd(xbh_pkg::ADDRESS_CYCLE_1, v, (k < 3) ? ok(8'h00) : 10'h100);
            cmd(xbh_pkg::ADDRESS_CYCLE_2, v, (k < 3) ? ok(8'h00) : 10'h100);
        end
        cmd(xbh_pkg::BUS_RESET_CYCLE, 8'h00, 10'h000);
        repeat (6) @(posedge i_sys_clk);
        check({7'h0, sel}, 8'h00);
        check({7'h0, o_attention}, 8'h00);
        stop_test();
    end
endmodule // xbh_host_tb
